// *** design/rpl_pkg.sv ***
// shared constants and preset tables for the rf protocol preset loader
package rpl_pkg;

  // ***************************************************************
  // sizes and protocol selection codes
  // ***************************************************************
  localparam int         PROT_REGS = 24;
  localparam int         ANT_REGS  = 18;
  localparam int         EE_AW     = 16;
  localparam logic [1:0] PROT_A106 = 2'h0;
  localparam logic [1:0] PROT_A212 = 2'h1;
  localparam logic [1:0] PROT_A424 = 2'h2;
  localparam logic [1:0] PROT_A848 = 2'h3;

  // ***************************************************************
  // register map of the rf configuration space
  // ***************************************************************
  localparam logic [7:0] PROT_REG_BASE = 8'h10;
  localparam logic [4:0] PROT_LAST_IDX = 5'h17;
  localparam logic [7:0] ANT_REG_FIRST = 8'h28;
  localparam logic [7:0] ANT_REG_LAST  = 8'h39;

  // offsets inside the protocol block
  localparam logic [7:0] IDX_TX_DATA_CONFIG      = 8'h02;
  localparam logic [7:0] IDX_TX_SYMBOL_FREQUENCY = 8'h04;
  localparam logic [7:0] IDX_RX_BIT_MODULATION   = 8'h10;
  localparam logic [7:0] IDX_RX_SYNC_VALUE_LOW   = 8'h13;
  localparam logic [7:0] IDX_RX_MODE_CONFIG      = 8'h15;

  // ***************************************************************
  // eeprom layout
  // ***************************************************************
  localparam logic [7:0]  EE_BLANK = 8'h00;
  localparam logic [15:0] ANT_EE_BASE [4] = '{16'h00C0, 16'h00D4, 16'h00E8, 16'h0100};

  // ***************************************************************
  // fixed protocol tables, one row per bit rate
  // ***************************************************************
  localparam logic [7:0] PROT_TAB [4][24] = '{
    '{8'h20, 8'h00, 8'h04, 8'h50, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h50, 8'h02, 8'h00, 8'h00, 8'h01, 8'h00, 8'h08, 8'h80, 8'hB2},
    '{8'h20, 8'h00, 8'h05, 8'h50, 8'h50, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h50, 8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0D, 8'h80, 8'hB2},
    '{8'h20, 8'h00, 8'h06, 8'h50, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h50, 8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0D, 8'h80, 8'hB2},
    '{8'h20, 8'h00, 8'h07, 8'h50, 8'h70, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h50, 8'h22, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0D, 8'h80, 8'hB2}};

  // ***************************************************************
  // factory antenna presets, driver_mode first, tx_amplitude second
  // ***************************************************************
  localparam logic [7:0] ANT_TAB [4][18] = '{
    '{8'h8E, 8'h12, 8'h39, 8'h0A, 8'h18, 8'h18, 8'h0F, 8'h21, 8'h00,
      8'hC0, 8'h12, 8'hCF, 8'h00, 8'h04, 8'h90, 8'h5C, 8'h12, 8'h0A},
    '{8'h8E, 8'hD2, 8'h11, 8'h0A, 8'h18, 8'h18, 8'h0F, 8'h10, 8'h00,
      8'hC0, 8'h12, 8'hCF, 8'h00, 8'h05, 8'h90, 8'h3C, 8'h12, 8'h0B},
    '{8'h8F, 8'hDE, 8'h11, 8'h0F, 8'h18, 8'h18, 8'h0F, 8'h07, 8'h00,
      8'hC0, 8'h12, 8'hCF, 8'h00, 8'h06, 8'h90, 8'h2B, 8'h12, 8'h0B},
    '{8'h8F, 8'hDB, 8'h21, 8'h0F, 8'h18, 8'h18, 8'h0F, 8'h02, 8'h00,
      8'hC0, 8'h12, 8'hCF, 8'h00, 8'h07, 8'h90, 8'h3A, 8'h12, 8'h0B}};

endpackage

// *** design/rpl_protocol_table.sv ***
// fixed per-protocol rf register table lookup
`timescale 1ns/1ps
module rpl_protocol_table (
  // selection
  input  wire logic [1:0] prot_sel,
  input  wire logic [4:0] idx,
  // result
  output logic      [7:0] value
);

  always_comb begin
    if (idx <= rpl_pkg::PROT_LAST_IDX) begin
      value = rpl_pkg::PROT_TAB[prot_sel][idx];
    end else begin
      value = rpl_pkg::EE_BLANK;
    end
  end

endmodule

// *** design/rpl_preset_eeprom.sv ***
// user eeprom image holding factory antenna presets, one cycle read latency
`timescale 1ns/1ps
module rpl_preset_eeprom (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // read port
  input  wire logic        rd_en,
  input  wire logic [15:0] rd_addr,
  output logic      [7:0]  rd_data_r
);

  logic [7:0]  rd_data_nxt;
  logic [15:0] off;

  // ***************************************************************
  // address decode over the preset blocks
  // ***************************************************************
  // only the preset blocks are modelled; any other byte reads blank
  always_comb begin
    rd_data_nxt = rd_data_r;
    off         = 16'h0000;
    if (rd_en) begin
      rd_data_nxt = rpl_pkg::EE_BLANK;
      for (int b = 0; b < 4; b++) begin
        off = rd_addr - rpl_pkg::ANT_EE_BASE[b];
        if (rd_addr >= rpl_pkg::ANT_EE_BASE[b] && off < 16'(rpl_pkg::ANT_REGS)) begin
          rd_data_nxt = rpl_pkg::ANT_TAB[b][off[4:0]];
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

endmodule

// *** design/rpl_loader.sv ***
// rf protocol preset loader: protocol-load and eeprom-copy command engine
`timescale 1ns/1ps
// What this block does
// - protocol load writes the fixed table, never the antenna registers.
// - type A 212 load sets 05, 50, 22, 00 and 0D.
// - type A 424 load sets 06, 60, receive bit modulation 22, mode 0D.
// - type A 848 load sets 07, 70, receive values as at 424.
// - factory antenna presets live in eeprom and can be copied to registers.
// - antenna registers are 0x28 to 0x39, one preset block per protocol.
// - type A 106 preset at C0 to D1, driver mode 8E first.
// - type A 212 preset at D4 to E5, same register order.
// - type A 424 preset at E8 to F9, driver mode 8F.
// - type A 848 preset at 0100 to 0111, same order.
module rpl_loader (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // protocol load command
  input  wire logic       rf_protocol_load_cmd,
  input  wire logic [1:0] protocol_sel,
  // eeprom copy command
  input  wire logic       eeprom_to_register_copy_cmd,
  input  wire logic [15:0] copy_ee_addr,
  input  wire logic [7:0] copy_reg_addr,
  input  wire logic [7:0] copy_count,
  // status
  output logic            busy,
  output logic            done,
  // rf configuration register write port
  output logic            cfg_wr_en,
  output logic      [7:0] cfg_wr_addr,
  output logic      [7:0] cfg_wr_data
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PLOAD,
    ST_ERD,
    ST_EWR
  } rpl_state_t;

  rpl_state_t  state_r;
  rpl_state_t  state_nxt;
  logic [4:0]  idx_r;
  logic [4:0]  idx_nxt;
  logic [1:0]  prot_r;
  logic [1:0]  prot_nxt;
  logic [15:0] ee_ptr_r;
  logic [15:0] ee_ptr_nxt;
  logic [7:0]  reg_ptr_r;
  logic [7:0]  reg_ptr_nxt;
  logic [7:0]  remain_r;
  logic [7:0]  remain_nxt;
  logic        wr_en_r;
  logic        wr_en_nxt;
  logic [7:0]  wr_addr_r;
  logic [7:0]  wr_addr_nxt;
  logic [7:0]  wr_data_r;
  logic [7:0]  wr_data_nxt;
  logic        wr_pl_r;
  logic        wr_pl_nxt;
  logic        done_r;
  logic        done_nxt;

  logic [7:0]  tab_value;
  logic [7:0]  ee_rdata;
  logic        ee_rd_en;
  logic        pl_go;
  logic        cp_go;

  // ***************************************************************
  // table and eeprom
  // ***************************************************************
  rpl_protocol_table u_table (
    .prot_sel (prot_r),
    .idx      (idx_r),
    .value    (tab_value)
  );

  rpl_preset_eeprom u_eeprom (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .rd_en     (ee_rd_en),
    .rd_addr   (ee_ptr_r),
    .rd_data_r (ee_rdata)
  );

  // ***************************************************************
  // command acceptance
  // ***************************************************************
  // commands are taken only when idle; a load beats a copy in the same cycle
  assign pl_go    = (state_r == ST_IDLE) && rf_protocol_load_cmd;
  assign cp_go    = (state_r == ST_IDLE) && eeprom_to_register_copy_cmd && !rf_protocol_load_cmd;
  assign ee_rd_en = (state_r == ST_ERD);
  assign busy     = (state_r != ST_IDLE);

  // ***************************************************************
  // sequencer
  // ***************************************************************
  always_comb begin
    state_nxt   = state_r;
    idx_nxt     = idx_r;
    prot_nxt    = prot_r;
    ee_ptr_nxt  = ee_ptr_r;
    reg_ptr_nxt = reg_ptr_r;
    remain_nxt  = remain_r;
    wr_en_nxt   = 1'b0;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    wr_pl_nxt   = wr_pl_r;
    done_nxt    = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (pl_go) begin
          prot_nxt  = protocol_sel;
          idx_nxt   = 5'h00;
          state_nxt = ST_PLOAD;
        end else if (cp_go) begin
          ee_ptr_nxt  = copy_ee_addr;
          reg_ptr_nxt = copy_reg_addr;
          remain_nxt  = copy_count;
          // an empty copy finishes at once rather than hang
          if (copy_count == 8'h00) begin
            done_nxt = 1'b1;
          end else begin
            state_nxt = ST_ERD;
          end
        end
      end
      ST_PLOAD: begin
        // the table block sits below the antenna range, so it never reaches it
        wr_en_nxt   = 1'b1;
        wr_pl_nxt   = 1'b1;
        wr_addr_nxt = rpl_pkg::PROT_REG_BASE + {3'b000, idx_r};
        wr_data_nxt = tab_value;
        idx_nxt     = idx_r + 5'h01;
        if (idx_r == rpl_pkg::PROT_LAST_IDX) begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
        end
      end
      ST_ERD: begin
        state_nxt = ST_EWR;
      end
      ST_EWR: begin
        wr_en_nxt   = 1'b1;
        wr_pl_nxt   = 1'b0;
        wr_addr_nxt = reg_ptr_r;
        wr_data_nxt = ee_rdata;
        ee_ptr_nxt  = ee_ptr_r + 16'h0001;
        reg_ptr_nxt = reg_ptr_r + 8'h01;
        remain_nxt  = remain_r - 8'h01;
        if (remain_r == 8'h01) begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
        end else begin
          state_nxt = ST_ERD;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r   <= ST_IDLE;
      idx_r     <= 5'h00;
      prot_r    <= rpl_pkg::PROT_A106;
      ee_ptr_r  <= 16'h0000;
      reg_ptr_r <= 8'h00;
      remain_r  <= 8'h00;
      wr_en_r   <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
      wr_pl_r   <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      idx_r     <= idx_nxt;
      prot_r    <= prot_nxt;
      ee_ptr_r  <= ee_ptr_nxt;
      reg_ptr_r <= reg_ptr_nxt;
      remain_r  <= remain_nxt;
      wr_en_r   <= wr_en_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
      wr_pl_r   <= wr_pl_nxt;
      done_r    <= done_nxt;
    end
  end

  assign cfg_wr_en   = wr_en_r;
  assign cfg_wr_addr = wr_addr_r;
  assign cfg_wr_data = wr_data_r;
  assign done        = done_r;

  // ***************************************************************
  // checks
  // ***************************************************************
  logic       pl_wr;
  logic [7:0] pl_off;

  assign pl_wr  = cfg_wr_en && wr_pl_r;
  assign pl_off = cfg_wr_addr - rpl_pkg::PROT_REG_BASE;

  sequence s_copy_start;
    cp_go && copy_count != 8'h00;
  endsequence

  sequence s_first_copy_write;
    ##3 cfg_wr_en && cfg_wr_addr == $past(copy_reg_addr, 3);
  endsequence

  a_pload_no_antenna: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pl_wr |-> (cfg_wr_addr < rpl_pkg::ANT_REG_FIRST || cfg_wr_addr > rpl_pkg::ANT_REG_LAST))
    else $error("protocol load wrote into the antenna range");

  a_pload_length: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pl_go |-> ##1 (!cfg_wr_en && !done) ##1 cfg_wr_en [*8] ##16 (cfg_wr_en && done))
    else $error("protocol load did not write 24 registers then finish");

  a_a212_values: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pl_wr && prot_r == rpl_pkg::PROT_A212 |->
      (pl_off != rpl_pkg::IDX_TX_DATA_CONFIG || cfg_wr_data == 8'h05) &&
      (pl_off != rpl_pkg::IDX_TX_SYMBOL_FREQUENCY || cfg_wr_data == 8'h50) &&
      (pl_off != rpl_pkg::IDX_RX_BIT_MODULATION || cfg_wr_data == 8'h22) &&
      (pl_off != rpl_pkg::IDX_RX_SYNC_VALUE_LOW || cfg_wr_data == 8'h00) &&
      (pl_off != rpl_pkg::IDX_RX_MODE_CONFIG || cfg_wr_data == 8'h0D))
    else $error("type A 212 load value wrong");

  a_a424_values: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pl_wr && prot_r == rpl_pkg::PROT_A424 |->
      (pl_off != rpl_pkg::IDX_TX_DATA_CONFIG || cfg_wr_data == 8'h06) &&
      (pl_off != rpl_pkg::IDX_TX_SYMBOL_FREQUENCY || cfg_wr_data == 8'h60) &&
      (pl_off != rpl_pkg::IDX_RX_BIT_MODULATION || cfg_wr_data == 8'h22) &&
      (pl_off != rpl_pkg::IDX_RX_MODE_CONFIG || cfg_wr_data == 8'h0D))
    else $error("type A 424 load value wrong");

  a_a848_values: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pl_wr && prot_r == rpl_pkg::PROT_A848 |->
      (pl_off != rpl_pkg::IDX_TX_DATA_CONFIG || cfg_wr_data == 8'h07) &&
      (pl_off != rpl_pkg::IDX_TX_SYMBOL_FREQUENCY || cfg_wr_data == 8'h70) &&
      (pl_off != rpl_pkg::IDX_RX_BIT_MODULATION || cfg_wr_data == 8'h22) &&
      (pl_off != rpl_pkg::IDX_RX_MODE_CONFIG || cfg_wr_data == 8'h0D))
    else $error("type A 848 load value wrong");

  a_copy_first_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_copy_start |-> s_first_copy_write)
    else $error("copy did not write the first register on time");

  a_copy_consecutive: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cfg_wr_en && !wr_pl_r && busy |-> ##2 cfg_wr_en && cfg_wr_addr == $past(cfg_wr_addr, 2) + 8'h01)
    else $error("copy skipped a register");

  a_ee_a106_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ee_rd_en && ee_ptr_r == 16'h00C0 |=> ee_rdata == 8'h8E)
    else $error("type A 106 preset does not start with 8E");

  a_ee_a212_span: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ee_rd_en && (ee_ptr_r == 16'h00D4 || ee_ptr_r == 16'h00E5) |=> ee_rdata != rpl_pkg::EE_BLANK)
    else $error("type A 212 preset ends misplaced");

  a_ee_a424_first: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ee_rd_en && ee_ptr_r == 16'h00E8 |=> ee_rdata == 8'h8F)
    else $error("type A 424 preset does not start with 8F");

  a_ee_a848_last: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ee_rd_en && ee_ptr_r == 16'h0111 |=> ee_rdata == 8'h0B)
    else $error("type A 848 preset last byte wrong");

  a_ee_gap_blank: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ee_rd_en && (ee_ptr_r == 16'h00D2 || ee_ptr_r == 16'h0112) |=> ee_rdata == rpl_pkg::EE_BLANK)
    else $error("preset block runs past 18 bytes");

endmodule

// *** bench/rpl_regfile_model.sv ***
// rf configuration register space model fed by the loader and by direct host writes
`timescale 1ns/1ps
module rpl_regfile_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // loader write port
  input  wire logic       cfg_wr_en,
  input  wire logic [7:0] cfg_wr_addr,
  input  wire logic [7:0] cfg_wr_data,
  // host direct access
  input  wire logic       host_wr_en,
  input  wire logic [7:0] host_addr,
  input  wire logic [7:0] host_wr_data,
  output logic      [7:0] host_rd_data,
  output int              wr_count
);
  // ***************************************************************
  // register array
  // ***************************************************************
  logic [7:0] regs [256];

  // host may write antenna registers itself, also to tune a preset after a copy
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_count <= 0;
    end else begin
      if (cfg_wr_en) begin
        regs[cfg_wr_addr] <= cfg_wr_data;
        wr_count          <= wr_count + 1;
      end
      if (host_wr_en) begin
        regs[host_addr] <= host_wr_data;
      end
    end
  end

  assign host_rd_data = regs[host_addr];
endmodule

// *** bench/rpl_loader_bench.sv ***
// self-checking testbench for the rf protocol preset loader
`timescale 1ns/1ps
module rpl_loader_bench;
  // ***************************************************************
  // signals
  // ***************************************************************
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        load_cmd = 1'b0;
  logic [1:0]  prot_sel = 2'h0;
  logic        copy_cmd = 1'b0;
  logic [15:0] ee_addr = 16'h0000;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  count = 8'h00;
  logic        busy, done, cfg_wr_en;
  logic [7:0]  cfg_wr_addr, cfg_wr_data, rd_data;
  logic        host_wr_en = 1'b0;
  logic [7:0]  host_addr = 8'h00;
  logic [7:0]  host_wr_data = 8'h00;
  int          wr_count, failures = 0, cmp_count = 0, cyc, n0;
  logic        b1;
  logic [7:0]  v;
  logic [7:0]  offs [5] = '{8'h12, 8'h14, 8'h20, 8'h23, 8'h25};
  logic [7:0]  exp_prot [4][5] = '{'{8'h04, 8'h40, 8'h02, 8'h01, 8'h08}, '{8'h05, 8'h50, 8'h22, 8'h00, 8'h0D},
                                   '{8'h06, 8'h60, 8'h22, 8'h00, 8'h0D}, '{8'h07, 8'h70, 8'h22, 8'h00, 8'h0D}};
  logic [15:0] ee_base [4] = '{16'h00C0, 16'h00D4, 16'h00E8, 16'h0100};
  logic [7:0]  exp_ant [4][3] = '{'{8'h8E, 8'h12, 8'h0A}, '{8'h8E, 8'hD2, 8'h0B},
                                  '{8'h8F, 8'hDE, 8'h0B}, '{8'h8F, 8'hDB, 8'h0B}};

  always #12.5 clk_sys = ~clk_sys;

  rpl_loader u_rpl_loader (.clk_sys(clk_sys), .sys_rst(sys_rst), .rf_protocol_load_cmd(load_cmd),
    .protocol_sel(prot_sel), .eeprom_to_register_copy_cmd(copy_cmd), .copy_ee_addr(ee_addr),
    .copy_reg_addr(reg_addr), .copy_count(count), .busy(busy), .done(done), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data));

  rpl_regfile_model u_rpl_regfile_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .cfg_wr_en(cfg_wr_en),
    .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data), .host_wr_en(host_wr_en), .host_addr(host_addr),
    .host_wr_data(host_wr_data), .host_rd_data(rd_data), .wr_count(wr_count));

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic host_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    host_wr_en   <= 1'b1;
    host_addr    <= a;
    host_wr_data <= d;
    @(posedge clk_sys);
    host_wr_en <= 1'b0;
  endtask

  task automatic host_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    host_addr <= a;
    @(posedge clk_sys);
    #1;
    d = rd_data;
  endtask

  // one command; with hit set a copy request is thrown in while the loader is busy
  task automatic run_cmd(input logic l, input logic c, input logic hit);
    @(posedge clk_sys);
    load_cmd <= l;
    copy_cmd <= c;
    n0 = wr_count;
    @(posedge clk_sys);
    load_cmd <= 1'b0;
    copy_cmd <= 1'b0;
    // look right after the taking edge too, so a done that follows at once is not missed
    #1;
    cyc = 1;
    b1  = busy;
    while (cyc < 60 && done !== 1'b1) begin
      @(posedge clk_sys);
      copy_cmd <= hit && cyc == 4;
      #1;
      cyc++;
    end
    if (done !== 1'b1) begin
      failures++;
      $display("[ERR] done wait expected pulse seen none");
      tally_and_finish();
    end
    // the model counts the last write one edge after it shows
    @(posedge clk_sys);
    #1;
  endtask

  // ***************************************************************
  // test sequence
  // ***************************************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // every bit rate; antenna register preloaded by the host must survive
    for (int p = 0; p < 4; p++) begin
      host_write(8'h28, 8'h5A);
      prot_sel <= p[1:0];
      run_cmd(1'b1, 1'b0, 1'b0);
      check("load done cycle", 16'(cyc), 16'd25);
      check("load busy", {15'h0, b1}, 16'h0001);
      check("load writes", 16'(wr_count - n0), 16'd24);
      for (int k = 0; k < 5; k++) begin
        host_read(offs[k], v);
        check("protocol reg", {8'h00, v}, {8'h00, exp_prot[p][k]});
      end
      host_read(8'h28, v);
      check("antenna kept", {8'h00, v}, 16'h005A);
    end
    $display("test protocol load finished");
    // factory presets copied into 0x28..0x39
    for (int p = 0; p < 4; p++) begin
      ee_addr  <= ee_base[p];
      reg_addr <= 8'h28;
      count    <= 8'd18;
      run_cmd(1'b0, 1'b1, 1'b0);
      check("copy done cycle", 16'(cyc), 16'd37);
      check("copy writes", 16'(wr_count - n0), 16'd18);
      host_read(8'h28, v);
      check("driver_mode", {8'h00, v}, {8'h00, exp_ant[p][0]});
      host_read(8'h29, v);
      check("tx_amplitude", {8'h00, v}, {8'h00, exp_ant[p][1]});
      host_read(8'h39, v);
      check("last antenna reg", {8'h00, v}, {8'h00, exp_ant[p][2]});
    end
    $display("test preset copy finished");
    // zero count, then a copy that wraps the register address
    count <= 8'd0;
    run_cmd(1'b0, 1'b1, 1'b0);
    check("empty copy cycle", 16'(cyc), 16'd1);
    check("empty copy busy", {15'h0, b1}, 16'h0000);
    check("empty copy writes", 16'(wr_count - n0), 16'd0);
    ee_addr  <= 16'h00C0;
    reg_addr <= 8'hFF;
    count    <= 8'd2;
    run_cmd(1'b0, 1'b1, 1'b0);
    host_read(8'hFF, v);
    check("wrap first", {8'h00, v}, 16'h008E);
    host_read(8'h00, v);
    check("wrap second", {8'h00, v}, 16'h0012);
    // copy across the end of the 848 block: bytes past its last entry read blank
    ee_addr  <= 16'h0110;
    reg_addr <= 8'h40;
    count    <= 8'd4;
    run_cmd(1'b0, 1'b1, 1'b0);
    host_read(8'h41, v);
    check("848 preset last", {8'h00, v}, 16'h000B);
    host_read(8'h42, v);
    check("past preset end", {8'h00, v}, 16'h0000);
    host_write(8'h29, 8'h33);
    host_read(8'h29, v);
    check("tuned amplitude", {8'h00, v}, 16'h0033);
    $display("test copy edges finished");
    // copy while busy is ignored; load wins over a copy in the same cycle
    prot_sel <= 2'h2;
    reg_addr <= 8'h28;
    count    <= 8'd18;
    run_cmd(1'b1, 1'b0, 1'b1);
    check("refused copy writes", 16'(wr_count - n0), 16'd24);
    run_cmd(1'b1, 1'b1, 1'b0);
    check("load wins cycle", 16'(cyc), 16'd25);
    check("load wins writes", 16'(wr_count - n0), 16'd24);
    host_read(8'h28, v);
    check("antenna after load", {8'h00, v}, 16'h008F);
    $display("test refusal finished");
    tally_and_finish();
  end
endmodule
